// [alert_params.svh]
`ifndef ALERT_PARAMS_SVH
`define ALERT_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses on the AHB-Lite slave)
`define OFS_CTRL 8'h00
`define OFS_WLAT 8'h04
`define OFS_WREC 8'h08
`define OFS_STAT 8'h0c
`define OFS_IEN 8'h10
`define OFS_ICLR 8'h14
`define OFS_STATE 8'h18

// ==========================================================================
// Control register fields and reset values
`define CTL_PAR_EN 0
`define CTL_CRC_EN 1
`define CTL_FAST 2
`define CTL_BC4_FIXED 3
`define CTL_DLL_LOCK 4
`define CTL_RST 5'h00
`define WLAT_RST 8'h09
`define WREC_RST 8'h0c

// ==========================================================================
// Event bits shared by status, enable and clear registers
`define EV_PAR 0
`define EV_CRC 1
`define EV_WR_START 2
`define EV_UNLOCKED_RD 3

// ==========================================================================
// Timing, in nanoseconds, in ref_clk cycles and in link clock cycles
`define CLK_NS 4
`define PAR_ON_MAX_NS 6
`define PAR_ON_CYC (`PAR_ON_MAX_NS / `CLK_NS)
`define CRC_ON_MAX_NS 13
`define CRC_ON_CYC (`CRC_ON_MAX_NS / `CLK_NS)
`define PAR_PW_SLOW 10'd72
`define PAR_PW_SLOW_MAX 10'd144
`define PAR_PW_FAST 10'd80
`define PAR_PW_FAST_MAX 10'd160
`define CRC_PW_MIN 10'd6
`define CRC_PW_MAX 10'd10
`define WR_START_BL8 10'd4
`define WR_START_BC4 10'd2
`define WRA_EXTRA 10'd1
`define ROW_BUSY_CK 10'd16

`endif

// [alert_pkg.sv]
package alert_pkg;

  // ========================================================================
  // Pins from the memory controller, all outside the ref_clk domain.
  typedef struct packed {
    logic ck;
    logic cke;
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic ap;
    logic bc_n;
    logic par;
    logic crc_err;
  } pins_t;

  // ========================================================================
  // Decoded command of one link clock edge.
  typedef enum logic [2:0] {
    CMD_DES,
    CMD_ACT,
    CMD_RD,
    CMD_WR,
    CMD_PRE,
    CMD_REF,
    CMD_OTHER
  } cmd_t;

endpackage : alert_pkg

// [pin_sync.sv]
`timescale 1ns/1ns

module pin_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire alert_pkg::pins_t pins,
  output alert_pkg::pins_t pins_sync
);
  import alert_pkg::*;

  // ========================================================================
  // Two-stage synchroniser; the first stage feeds only the second.
  typedef struct packed {
    pins_t s1_r;
    pins_t s2_r;
  } sync_t;

  sync_t s;
  sync_t s_nxt;

  always_comb begin
    s_nxt = s;
    s_nxt.s1_r = pins;
    s_nxt.s2_r = s.s1_r;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= s_nxt;
    end
  end

  assign pins_sync = s.s2_r;

endmodule : pin_sync

// [alert_ctrl.sv]
`timescale 1ns/1ns
`include "alert_params.svh"

module alert_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire alert_pkg::pins_t pins,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic alert_out,
  output logic alert_oen,
  output logic wr_start,
  output logic pwr_down,
  output logic irq
);
  import alert_pkg::*;

  // ========================================================================
  // State
  typedef struct packed {
    logic ck_r;
    logic cke_r;
    logic crc_r;
    logic [4:0] ctrl_r;
    logic [7:0] wlat_r;
    logic [7:0] wrec_r;
    logic [3:0] stat_r;
    logic [3:0] ien_r;
    logic [9:0] par_cnt_r;
    logic [9:0] crc_cnt_r;
    logic [9:0] wr_cnt_r;
    logic [9:0] busy_cnt_r;
    logic alert_out_r;
    logic alert_oen_r;
    logic wr_start_r;
    logic pwr_down_r;
    logic irq_r;
    logic a_wr_r;
    logic [7:0] a_addr_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
  } st_t;

  st_t s;
  st_t s_nxt;
  pins_t p;

  logic ck_rise;
  logic crc_rise;
  logic par_bad;
  logic par_det;
  logic accept;
  cmd_t cmd;
  logic [9:0] wr_off;
  logic [3:0] ev;

  pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pins(pins),
    .pins_sync(p)
  );

  function automatic cmd_t decode(input pins_t q);
    cmd_t c;
    c = CMD_OTHER;
    if (q.cs_n) begin
      c = CMD_DES;
    end else if (!q.act_n) begin
      c = CMD_ACT;
    end else begin
      case ({q.ras_n, q.cas_n, q.we_n})
        3'b101: c = CMD_RD;
        3'b100: c = CMD_WR;
        3'b010: c = CMD_PRE;
        3'b001: c = CMD_REF;
        default: c = CMD_OTHER;
      endcase
    end
    return c;
  endfunction : decode

  function automatic logic [31:0] read_mux(input st_t q, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `OFS_CTRL: d = {27'h000_0000, q.ctrl_r};
      `OFS_WLAT: d = {24'h00_0000, q.wlat_r};
      `OFS_WREC: d = {24'h00_0000, q.wrec_r};
      `OFS_STAT: d = {28'h000_0000, q.stat_r};
      `OFS_IEN: d = {28'h000_0000, q.ien_r};
      `OFS_STATE: d = {28'h000_0000, q.pwr_down_r, !q.alert_oen_r,
                       q.busy_cnt_r != 10'h000, q.wr_cnt_r != 10'h000};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_mux

  // ========================================================================
  // Link sampling and command decode
  always_comb begin
    ck_rise = p.ck && !s.ck_r;
    crc_rise = p.crc_err && !s.crc_r && s.ctrl_r[`CTL_CRC_EN];
    cmd = decode(p);
    par_bad = ^{p.act_n, p.ras_n, p.cas_n, p.we_n, p.ap, p.bc_n, p.par};
    par_det = ck_rise && !p.cs_n && s.ctrl_r[`CTL_PAR_EN] && par_bad
              && s.par_cnt_r == 10'h000;
    // Commands inside the parity alert window are dropped, so the controller has
    // to replay everything it issued around the errant command.
    accept = ck_rise && cmd != CMD_DES && !par_det
             && s.par_cnt_r == 10'h000;
    // Only the fixed chop mode moves the start point two edges earlier.
    wr_off = s.ctrl_r[`CTL_BC4_FIXED] ? `WR_START_BC4 : `WR_START_BL8;
  end

  // ========================================================================
  // Next state
  always_comb begin
    s_nxt = s;
    ev = 4'h0;
    s_nxt.ck_r = p.ck;
    s_nxt.crc_r = p.crc_err;
    s_nxt.wr_start_r = 1'b0;
    if (ck_rise) begin
      s_nxt.cke_r = p.cke;
    end

    // Parity alert: starts on the detecting cycle, one extra edge of margin
    // keeps the low time above the minimum despite sampling skew.
    if (par_det) begin
      s_nxt.par_cnt_r = (s.ctrl_r[`CTL_FAST] ? `PAR_PW_FAST
                                             : `PAR_PW_SLOW) + 10'd1;
      ev[`EV_PAR] = 1'b1;
    end else if (ck_rise && s.par_cnt_r != 10'h000) begin
      s_nxt.par_cnt_r = s.par_cnt_r - 10'd1;
    end

    // A new CRC error restarts the pulse rather than stretching it.
    if (crc_rise) begin
      s_nxt.crc_cnt_r = `CRC_PW_MIN + 10'd1;
      ev[`EV_CRC] = 1'b1;
    end else if (ck_rise && s.crc_cnt_r != 10'h000) begin
      s_nxt.crc_cnt_r = s.crc_cnt_r - 10'd1;
    end

    // Only one write is tracked; a later write replaces an earlier one.
    if (accept && cmd == CMD_WR) begin
      s_nxt.wr_cnt_r = {2'b00, s.wlat_r} + wr_off;
    end else if (ck_rise && s.wr_cnt_r != 10'h000) begin
      s_nxt.wr_cnt_r = s.wr_cnt_r - 10'd1;
      if (s.wr_cnt_r == 10'd1) begin
        s_nxt.wr_start_r = 1'b1;
        ev[`EV_WR_START] = 1'b1;
      end
    end

    if (accept && cmd == CMD_WR && p.ap) begin
      s_nxt.busy_cnt_r = {2'b00, s.wlat_r} + wr_off
                         + {2'b00, s.wrec_r} + `WRA_EXTRA;
    end else if (accept && (cmd == CMD_ACT || cmd == CMD_PRE
                 || cmd == CMD_REF || (cmd == CMD_RD && p.ap))) begin
      s_nxt.busy_cnt_r = `ROW_BUSY_CK;
    end else if (ck_rise && s.busy_cnt_r != 10'h000) begin
      s_nxt.busy_cnt_r = s.busy_cnt_r - 10'd1;
    end

    if (accept && cmd == CMD_RD && !s.ctrl_r[`CTL_DLL_LOCK]) begin
      ev[`EV_UNLOCKED_RD] = 1'b1;
    end

    // Clock enable low is taken at once; power-down waits for idle.
    s_nxt.pwr_down_r = !s_nxt.cke_r
                       && s_nxt.busy_cnt_r == 10'h000;

    // The pin is open drain: pull low by enabling, release otherwise.
    s_nxt.alert_out_r = 1'b0;
    s_nxt.alert_oen_r = s_nxt.par_cnt_r == 10'h000
                        && s_nxt.crc_cnt_r == 10'h000;

    // ======================================================================
    // AHB-Lite slave: zero wait states, always OKAY
    s_nxt.hreadyout_r = 1'b1;
    s_nxt.hresp_r = 1'b0;
    s_nxt.a_wr_r = 1'b0;
    if (s.a_wr_r) begin
      case (s.a_addr_r)
        `OFS_CTRL: s_nxt.ctrl_r = hwdata[4:0];
        `OFS_WLAT: s_nxt.wlat_r = hwdata[7:0];
        `OFS_WREC: s_nxt.wrec_r = hwdata[7:0];
        `OFS_IEN: s_nxt.ien_r = hwdata[3:0];
        `OFS_ICLR: s_nxt.stat_r = s.stat_r & ~hwdata[3:0];
        default: s_nxt.ctrl_r = s.ctrl_r;
      endcase
    end
    // Events win over a clear landing in the same cycle.
    s_nxt.stat_r = s_nxt.stat_r | ev;
    s_nxt.irq_r = |(s_nxt.stat_r & s_nxt.ien_r);
    if (hsel && htrans[1] && hready) begin
      s_nxt.a_wr_r = hwrite;
      s_nxt.a_addr_r = haddr;
      if (!hwrite) begin
        s_nxt.hrdata_r = read_mux(s, haddr);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl_r <= `CTL_RST;
      s.wlat_r <= `WLAT_RST;
      s.wrec_r <= `WREC_RST;
      s.alert_oen_r <= 1'b1;
      s.hreadyout_r <= 1'b1;
    end else begin
      s <= s_nxt;
    end
  end

  assign hrdata = s.hrdata_r;
  assign hreadyout = s.hreadyout_r;
  assign hresp = s.hresp_r;
  assign alert_out = s.alert_out_r;
  assign alert_oen = s.alert_oen_r;
  assign wr_start = s.wr_start_r;
  assign pwr_down = s.pwr_down_r;
  assign irq = s.irq_r;

  // ========================================================================
  // Checks
  localparam int PAR_ON = `PAR_ON_CYC;
  localparam int CRC_ON = `CRC_ON_CYC;
  logic [9:0] par_len;
  logic [9:0] crc_len;
  logic [9:0] wr_len;
  logic [9:0] wr_exp;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_len <= 10'h000;
      crc_len <= 10'h000;
      wr_len <= 10'h000;
      wr_exp <= 10'h000;
    end else begin
      if (par_det) begin
        par_len <= 10'h000;
      end else if (ck_rise && s.par_cnt_r != 10'h000) begin
        par_len <= par_len + 10'd1;
      end
      if (crc_rise) begin
        crc_len <= 10'h000;
      end else if (ck_rise && s.crc_cnt_r != 10'h000) begin
        crc_len <= crc_len + 10'd1;
      end
      if (accept && cmd == CMD_WR) begin
        wr_len <= 10'h000;
        wr_exp <= {2'b00, s.wlat_r} + wr_off;
      end else if (ck_rise && s.wr_cnt_r != 10'h000) begin
        wr_len <= wr_len + 10'd1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_par_alert_on: assert property (
    par_det |-> ##[1:PAR_ON] !alert_oen)
    else $error("parity alert late");

  a_par_pulse_width: assert property (
    $fell(s.par_cnt_r != 10'h000) |->
      (s.ctrl_r[`CTL_FAST] ? (par_len >= `PAR_PW_FAST
                              && par_len <= `PAR_PW_FAST_MAX)
                           : (par_len >= `PAR_PW_SLOW
                              && par_len <= `PAR_PW_SLOW_MAX)))
    else $error("parity alert width out of range");

  a_crc_alert_on: assert property (
    crc_rise |-> ##[1:CRC_ON] !alert_oen)
    else $error("crc alert late");

  a_crc_pulse_width: assert property (
    $fell(s.crc_cnt_r != 10'h000) |->
      crc_len >= `CRC_PW_MIN && crc_len <= `CRC_PW_MAX)
    else $error("crc alert width out of range");

  a_wr_start_time: assert property (
    $rose(wr_start) |-> wr_len == wr_exp)
    else $error("internal write start at wrong edge");

  a_wra_busy_load: assert property (
    (accept && cmd == CMD_WR && p.ap) |=>
      s.busy_cnt_r == {2'b00, $past(s.wlat_r)} + $past(wr_off)
                      + {2'b00, $past(s.wrec_r)} + `WRA_EXTRA)
    else $error("autoprecharge write busy count wrong");

  a_pd_waits_idle: assert property (
    (s.busy_cnt_r != 10'h000) |-> !pwr_down)
    else $error("power-down entered while busy");

  a_alert_idle_high: assert property (
    (s.par_cnt_r == 10'h000 && s.crc_cnt_r == 10'h000) |-> alert_oen
      && !alert_out)
    else $error("alert driven outside an error pulse");

endmodule : alert_ctrl

// [ctl_model.sv]
`timescale 1ns/1ns

// ==========================================================================
// Controller side of the link: free running clock, commands and CRC errors.
module ctl_model (
  input wire logic alert_n,
  output alert_pkg::pins_t pins
);
  import alert_pkg::*;
  localparam int TCK_NS = 64;
  int rises = 0;
  int last = 0;
  time t_cmd = 0;

  // Clock low, cke high, deselect with even parity, no CRC error.
  initial pins = 11'h3fc;
  always #(TCK_NS / 2) pins.ck = ~pins.ck;
  always @(posedge pins.ck) rises = rises + 1;

  // A command is never sent while alert is low, so only deselects reach the
  // device in that time and nothing issued near an error is relied upon.
  // Reads are never issued, so the loop lock question does not arise.
  task automatic cmd(input logic [3:0] arcw, input logic ap, bc, bad);
    wait (alert_n === 1'b1);
    @(negedge pins.ck);
    {pins.cs_n, pins.act_n, pins.ras_n, pins.cas_n, pins.we_n, pins.ap,
      pins.bc_n, pins.par} <= {1'b0, arcw, ap, bc, ^{arcw, ap, bc} ^ bad};
    last = rises + 1;
    @(posedge pins.ck);
    t_cmd = $time;
    @(negedge pins.ck);
    {pins.cs_n, pins.act_n, pins.ras_n, pins.cas_n, pins.we_n, pins.ap,
      pins.bc_n, pins.par} <= 8'hfe;
  endtask : cmd

  task automatic crc();
    @(negedge pins.ck);
    pins.crc_err <= 1'b1;
    t_cmd = $time;
    repeat (2) @(negedge pins.ck);
    pins.crc_err <= 1'b0;
  endtask : crc

  task automatic set_cke(input logic v);
    @(negedge pins.ck);
    pins.cke <= v;
  endtask : set_cke

  // Mask is never enabled, so the plain recovery values apply.
  function automatic int ru(input int ns);
    return (ns + TCK_NS - 1) / TCK_NS;
  endfunction : ru
endmodule : ctl_model

// [tb.sv]
`timescale 1ns/1ns
`include "alert_params.svh"

module tb;
  import alert_pkg::*;
  localparam int PL = 5;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic alert_out;
  logic alert_oen;
  logic wr_start;
  logic pwr_down;
  logic irq;
  logic alert_n;
  pins_t pins;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] q;
  int n;

  always #2 ref_clk = ~ref_clk;
  // The alert line is open drain with a pull-up.
  assign alert_n = alert_oen ? 1'b1 : alert_out;

  ctl_model i_ctl (.alert_n(alert_n), .pins(pins));
  alert_ctrl i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .pins(pins),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .alert_out(alert_out),
    .alert_oen(alert_oen), .wr_start(wr_start), .pwr_down(pwr_down),
    .irq(irq));

  // ========================================================================
  // Checks and bus cycles
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rng(input logic [31:0] got, lo, hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo,
        hi);
    end
  endtask : rng

  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk(hresp, 0);
  endtask : ahb

  // ========================================================================
  // Scenarios
  task automatic t_reset();
    chk(alert_n, 1);
    chk(irq, 0);
    ahb(0, `OFS_WLAT, 0);
    chk(q, `WLAT_RST);
    ahb(0, `OFS_WREC, 0);
    chk(q, `WREC_RST);
    ahb(0, 8'h1c, 0);
    chk(q, 0);
    ahb(1, `OFS_WREC, i_ctl.ru(700));
    ahb(0, `OFS_WREC, 0);
    chk(q, 11);
    $display("test reset done");
  endtask : t_reset

  task automatic t_write();
    ahb(1, `OFS_WLAT, 2);
    ahb(1, `OFS_IEN, 4);
    for (int i = 0; i < 3; i++) begin
      ahb(1, `OFS_CTRL, 32'(i == 1) << `CTL_BC4_FIXED);
      ahb(1, `OFS_ICLR, 32'hf);
      // The flops launched at the last bus edge are only settled here.
      @(negedge ref_clk);
      chk(irq, 0);
      i_ctl.cmd(4'b1100, 1'b1, i == 0, 1'b0);
      @(posedge wr_start);
      chk(i_ctl.rises - i_ctl.last, (i == 1) ? 4 : 6);
      @(posedge ref_clk);
      chk(irq, 1);
      ahb(0, `OFS_STAT, 0);
      chk(q, 4);
    end
    ahb(1, `OFS_IEN, 0);
    @(negedge ref_clk);
    chk(irq, 0);
    $display("test write start done");
  endtask : t_write

  task automatic t_parity(input logic fast);
    time t_al;
    ahb(1, `OFS_ICLR, 32'hf);
    ahb(1, `OFS_CTRL, 32'h1 | (32'(fast) << `CTL_FAST));
    // The fall is timed where it happens; the join waits for the model too.
    fork
      i_ctl.cmd(4'b1010, 1'b1, 1'b1, 1'b1);
      begin
        @(negedge alert_n);
        t_al = $time;
        n = i_ctl.rises;
      end
    join
    rng(t_al - i_ctl.t_cmd, 0, PL * 64 + 6);
    @(posedge alert_n);
    rng(i_ctl.rises - n, fast ? 80 : 72, fast ? 160 : 144);
    ahb(0, `OFS_STAT, 0);
    chk(q, 32'h1);
    $display("test parity done");
  endtask : t_parity

  task automatic t_crc();
    time t_al;
    ahb(1, `OFS_CTRL, 32'h1 << `CTL_CRC_EN);
    fork
      i_ctl.crc();
      begin
        @(negedge alert_n);
        t_al = $time;
        n = i_ctl.rises;
      end
    join
    rng(t_al - i_ctl.t_cmd, 3, 13);
    @(posedge alert_n);
    rng(i_ctl.rises - n, 6, 10);
    chk(alert_n, 1);
    ahb(0, `OFS_STAT, 0);
    chk(q[`EV_CRC], 1);
    $display("test crc done");
  endtask : t_crc

  task automatic t_power();
    i_ctl.cmd(4'b0111, 1'b1, 1'b1, 1'b0);
    i_ctl.set_cke(1'b0);
    repeat (4) @(posedge pins.ck);
    chk(pwr_down, 0);
    repeat (16) @(posedge pins.ck);
    chk(pwr_down, 1);
    ahb(0, `OFS_STATE, 0);
    chk(q, 32'h8);
    i_ctl.set_cke(1'b1);
    $display("test power down done");
  endtask : t_power

  // ========================================================================
  // Run control
  task automatic conclude();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    #100000;
    err_count++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_reset();
    t_write();
    t_parity(1'b0);
    t_parity(1'b1);
    t_crc();
    t_power();
    conclude();
  end
endmodule : tb
